// ### rtl/wwd_pkg.sv
// Constants, field layout and types of the windowed watchdog.
// Assumes a 125 MHz system clock and a Wishbone slave with 32-bit data.
package wwd_pkg;
	// System clock and nominal low-power RC rate
	localparam int CLK_FREQ_HZ = 125_000_000;
	localparam int LOW_POWER_RC_OSC_FREQ_HZ = 32_000;
	localparam int LOW_POWER_RC_OSC_DIV = CLK_FREQ_HZ / LOW_POWER_RC_OSC_FREQ_HZ;
	localparam int LOW_POWER_RC_OSC_CNT_W = 12;
	localparam logic [LOW_POWER_RC_OSC_CNT_W-1:0] LOW_POWER_RC_OSC_DIV_M1 = LOW_POWER_RC_OSC_CNT_W'(LOW_POWER_RC_OSC_DIV - 1);

	// Prescaler: 5-bit or 7-bit
	localparam int PRE_W = 7;
	localparam int PRE_LO_SH = 5;
	localparam int PRE_HI_SH = 7;
	localparam logic [PRE_W-1:0] PRE_LO_M1 = 7'h1F;
	localparam logic [PRE_W-1:0] PRE_HI_M1 = 7'h7F;

	// Postscaler: 16 power-of-two ratios
	localparam int POST_SEL_W = 4;
	localparam int POST_W = 15;
	localparam int WIN_W = 26;

	// Register bus
	localparam int WB_ADR_W = 4;
	localparam int WB_DAT_W = 32;
	localparam int WB_SEL_W = 4;
	localparam logic [WB_ADR_W-1:0] OFS_CONFIG = 4'h0;
	localparam logic [WB_ADR_W-1:0] OFS_RESET_CONTROL_REG = 4'h4;
	localparam logic [WB_ADR_W-1:0] OFS_CMD = 4'h8;
	localparam logic [WB_ADR_W-1:0] OFS_STATUS = 4'hC;

	// Watchdog configuration word
	localparam int CFG_W = 8;
	localparam int CFG_POST_LSB = 0;
	localparam int CFG_PRE_BIT = 4;
	localparam int CFG_WINDOW_DISABLE_BIT = 6;
	localparam int CFG_HWEN_BIT = 7;
	localparam logic [CFG_W-1:0] CFG_MASK = 8'hDF;
	localparam logic [CFG_W-1:0] CFG_RST = 8'hDF;

	// Reset control register
	localparam int RESET_CONTROL_REG_IDLE_BIT = 2;
	localparam int RESET_CONTROL_REG_SLEEP_BIT = 3;
	localparam int RESET_CONTROL_REG_TO_BIT = 4;
	localparam int RESET_CONTROL_REG_SWEN_BIT = 5;

	// Command register (instruction strobes)
	localparam int CMD_CLR_BIT = 0;
	localparam int CMD_SLEEP_BIT = 1;
	localparam int CMD_IDLE_BIT = 2;

	// Status register
	localparam int STAT_PRE_LSB = 0;
	localparam int STAT_POST_LSB = 7;
	localparam int STAT_WIN_BIT = 22;
	localparam int STAT_RUN_BIT = 23;
	localparam int STAT_LOCK_BIT = 24;

	typedef enum logic [2:0] {
		MODE_RUN = 3'b001,
		MODE_SLEEP = 3'b010,
		MODE_IDLE = 3'b100
	} wwd_mode_e;
endpackage : wwd_pkg

// ### rtl/wwd_core_if.sv
// Link between the watchdog control logic and its counter chain.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface wwd_core_if;
	import wwd_pkg::*;
	logic tick;
	logic clear;
	logic run;
	logic pre_sel;
	logic [POST_SEL_W-1:0] post_sel;
	logic timeout;
	logic window_open;
	logic [PRE_W-1:0] pre_cnt;
	logic [POST_W-1:0] post_cnt;

	modport core (
		input tick, clear, run, pre_sel, post_sel,
		output timeout, window_open, pre_cnt, post_cnt
	);
	modport ctrl (
		output tick, clear, run, pre_sel, post_sel,
		input timeout, window_open, pre_cnt, post_cnt
	);
endinterface : wwd_core_if

// ### rtl/wwd_core.sv
// Prescaler and postscaler counter chain of the watchdog.
// Assumes tick is a one-cycle pulse at the low-power RC rate.
`timescale 1ns/1ps
module wwd_core (
	input wire logic clock_in,
	input wire logic srst_in,
	wwd_core_if.core cif
);
	import wwd_pkg::*;

	typedef struct packed {
		logic [PRE_W-1:0] pre;
		logic [POST_W-1:0] post;
		logic timeout;
	} wwd_core_s;

	wwd_core_s s_r;
	wwd_core_s s_nxt;
	logic [PRE_W-1:0] pre_top;
	logic [POST_W-1:0] post_top;
	logic [WIN_W-1:0] elapsed;
	logic [WIN_W-1:0] total;

	always_comb begin
		s_nxt = s_r;
		s_nxt.timeout = 1'b0;
		pre_top = cif.pre_sel ? PRE_HI_M1 : PRE_LO_M1;
		post_top = POST_W'((32'h1 << cif.post_sel) - 32'h1);
		elapsed = (WIN_W'(s_r.post) << (cif.pre_sel ? PRE_HI_SH : PRE_LO_SH))
			+ WIN_W'(s_r.pre);
		total = WIN_W'(1) << (WIN_W'(cif.post_sel)
			+ WIN_W'(cif.pre_sel ? PRE_HI_SH : PRE_LO_SH));
		// Final quarter of the period
		cif.window_open = (elapsed << 2) >= ((total << 1) + total);
		if (cif.clear || !cif.run) begin
			s_nxt.pre = '0;
			s_nxt.post = '0;
		end else if (cif.tick) begin
			if (s_r.pre == pre_top) begin
				s_nxt.pre = '0;
				if (s_r.post == post_top) begin
					s_nxt.post = '0;
					s_nxt.timeout = 1'b1;
				end else begin
					s_nxt.post = s_r.post + POST_W'(1);
				end
			end else begin
				s_nxt.pre = s_r.pre + PRE_W'(1);
			end
		end
		if (srst_in) begin
			s_nxt = '0;
		end
	end

	always_ff @(posedge clock_in) begin
		s_r <= s_nxt;
	end

	assign cif.timeout = s_r.timeout;
	assign cif.pre_cnt = s_r.pre;
	assign cif.post_cnt = s_r.post;
endmodule : wwd_core

// ### rtl/wwd_top.sv
// Windowed watchdog timer with a Wishbone classic register slave.
// Assumes instruction strobes arrive as command-register writes and that
// dev_reset_in, clk_switch_done_in and wake_event_in are on clock_in.
`timescale 1ns/1ps
module wwd_top #(
	parameter int LOW_POWER_RC_OSC_DIV_P = wwd_pkg::LOW_POWER_RC_OSC_DIV
) (
	input wire logic clock_in,
	input wire logic srst_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [wwd_pkg::WB_ADR_W-1:0] wb_adr_in,
	input wire logic [wwd_pkg::WB_SEL_W-1:0] wb_sel_in,
	input wire logic [wwd_pkg::WB_DAT_W-1:0] wb_dat_in,
	output logic [wwd_pkg::WB_DAT_W-1:0] wb_dat_out,
	output logic wb_ack_out,
	input wire logic dev_reset_in,
	input wire logic clk_switch_done_in,
	input wire logic wake_event_in,
	output logic low_power_rc_osc_enable_out,
	output logic wdt_reset_out,
	output logic wake_out,
	output logic sleep_out,
	output logic idle_out
);
	import wwd_pkg::*;

	localparam logic [LOW_POWER_RC_OSC_CNT_W-1:0] DIV_M1 = LOW_POWER_RC_OSC_CNT_W'(LOW_POWER_RC_OSC_DIV_P - 1);

	typedef struct packed {
		logic [LOW_POWER_RC_OSC_CNT_W-1:0] low_power_rc_osc_cnt;
		logic low_power_rc_osc_tick;
		logic [CFG_W-1:0] cfg;
		logic cfg_locked;
		logic swen;
		logic to_flag;
		logic sleep_flag;
		logic idle_flag;
		wwd_mode_e mode;
		logic clear;
		logic ack;
		logic [WB_DAT_W-1:0] rdata;
		logic rst_pulse;
		logic wake_pulse;
	} wwd_top_s;

	wwd_top_s s_r;
	wwd_top_s s_nxt;
	wwd_core_if cif ();

	logic run;
	logic req;
	logic wr;
	logic any_reset;
	logic clear_now;
	logic in_save;
	logic early_clear;
	logic cmd_clr;
	logic cmd_sleep;
	logic cmd_idle;
	logic [WB_DAT_W-1:0] rd;

	wwd_core u_core (
		.clock_in(clock_in),
		.srst_in(srst_in),
		.cif(cif)
	);

	assign cif.tick = s_r.low_power_rc_osc_tick;
	assign cif.clear = s_r.clear;
	assign cif.run = run;
	assign cif.pre_sel = s_r.cfg[CFG_PRE_BIT];
	assign cif.post_sel = s_r.cfg[CFG_POST_LSB +: POST_SEL_W];

	always_comb begin
		s_nxt = s_r;
		s_nxt.ack = 1'b0;
		s_nxt.low_power_rc_osc_tick = 1'b0;
		s_nxt.rst_pulse = 1'b0;
		s_nxt.wake_pulse = 1'b0;
		rd = '0;
		clear_now = 1'b0;
		early_clear = 1'b0;

		// Enable: forced by configuration or granted by software
		run = s_r.cfg[CFG_HWEN_BIT] | s_r.swen;
		in_save = s_r.mode != MODE_RUN;

		// Nominal 32 kHz tick from the system clock
		if (run) begin
			if (s_r.low_power_rc_osc_cnt == DIV_M1) begin
				s_nxt.low_power_rc_osc_cnt = '0;
				s_nxt.low_power_rc_osc_tick = 1'b1;
			end else begin
				s_nxt.low_power_rc_osc_cnt = s_r.low_power_rc_osc_cnt + LOW_POWER_RC_OSC_CNT_W'(1);
			end
		end else begin
			s_nxt.low_power_rc_osc_cnt = '0;
		end

		// Bus decode: one-cycle answer, byte lane 0 holds every writable field
		req = wb_cyc_in & wb_stb_in & ~s_r.ack;
		wr = req & wb_we_in & wb_sel_in[0];
		cmd_clr = wr && (wb_adr_in == OFS_CMD) && wb_dat_in[CMD_CLR_BIT];
		cmd_sleep = wr && (wb_adr_in == OFS_CMD) && wb_dat_in[CMD_SLEEP_BIT];
		cmd_idle = wr && (wb_adr_in == OFS_CMD) && wb_dat_in[CMD_IDLE_BIT]
			&& !wb_dat_in[CMD_SLEEP_BIT];

		if (req) begin
			s_nxt.ack = 1'b1;
			case (wb_adr_in)
				OFS_CONFIG: begin
					rd[CFG_W-1:0] = s_r.cfg;
				end
				OFS_RESET_CONTROL_REG: begin
					rd[RESET_CONTROL_REG_SWEN_BIT] = s_r.swen;
					rd[RESET_CONTROL_REG_TO_BIT] = s_r.to_flag;
					rd[RESET_CONTROL_REG_SLEEP_BIT] = s_r.sleep_flag;
					rd[RESET_CONTROL_REG_IDLE_BIT] = s_r.idle_flag;
				end
				OFS_STATUS: begin
					rd[STAT_PRE_LSB +: PRE_W] = cif.pre_cnt;
					rd[STAT_POST_LSB +: POST_W] = cif.post_cnt;
					rd[STAT_WIN_BIT] = cif.window_open;
					rd[STAT_RUN_BIT] = run;
					rd[STAT_LOCK_BIT] = s_r.cfg_locked;
				end
				default: begin
					rd = '0;
				end
			endcase
			s_nxt.rdata = wb_we_in ? '0 : rd;
		end

		// Configuration word is write-once until power-on reset
		if (wr && (wb_adr_in == OFS_CONFIG) && !s_r.cfg_locked) begin
			s_nxt.cfg = wb_dat_in[CFG_W-1:0] & CFG_MASK;
			s_nxt.cfg_locked = 1'b1;
		end

		// Software writes zero to a flag to clear it
		if (wr && (wb_adr_in == OFS_RESET_CONTROL_REG)) begin
			s_nxt.swen = wb_dat_in[RESET_CONTROL_REG_SWEN_BIT];
			s_nxt.to_flag = s_r.to_flag & wb_dat_in[RESET_CONTROL_REG_TO_BIT];
			s_nxt.sleep_flag = s_r.sleep_flag & wb_dat_in[RESET_CONTROL_REG_SLEEP_BIT];
			s_nxt.idle_flag = s_r.idle_flag & wb_dat_in[RESET_CONTROL_REG_IDLE_BIT];
		end

		// Clear instruction, only meaningful in normal run
		if (cmd_clr && !in_save) begin
			if (run && !s_r.cfg[CFG_WINDOW_DISABLE_BIT] && !cif.window_open) begin
				early_clear = 1'b1;
			end else begin
				clear_now = 1'b1;
			end
		end

		// Power-save instruction
		if ((cmd_sleep || cmd_idle) && !in_save) begin
			clear_now = 1'b1;
			if (cmd_sleep) begin
				s_nxt.mode = MODE_SLEEP;
				s_nxt.sleep_flag = 1'b1;
			end else begin
				s_nxt.mode = MODE_IDLE;
				s_nxt.idle_flag = 1'b1;
			end
		end

		// Clock switch completion
		if (clk_switch_done_in) begin
			clear_now = 1'b1;
		end

		// Other wake source ends sleep or idle
		if (in_save && wake_event_in) begin
			s_nxt.mode = MODE_RUN;
			s_nxt.wake_pulse = 1'b1;
			clear_now = 1'b1;
		end

		// Time-out: wake from power save, else reset; counter runs in both
		if (cif.timeout) begin
			s_nxt.to_flag = 1'b1;
			if (in_save) begin
				s_nxt.mode = MODE_RUN;
				s_nxt.wake_pulse = 1'b1;
				clear_now = 1'b1;
			end else begin
				s_nxt.rst_pulse = 1'b1;
			end
		end

		// Early clear in window mode
		if (early_clear) begin
			s_nxt.rst_pulse = 1'b1;
			s_nxt.to_flag = 1'b1;
		end

		// Device reset from any source, the watchdog's own included
		any_reset = dev_reset_in | s_r.rst_pulse;
		if (any_reset) begin
			s_nxt.swen = 1'b0;
			s_nxt.mode = MODE_RUN;
			clear_now = 1'b1;
		end

		s_nxt.clear = clear_now;

		if (srst_in) begin
			s_nxt.low_power_rc_osc_cnt = '0;
			s_nxt.low_power_rc_osc_tick = 1'b0;
			s_nxt.cfg = CFG_RST;
			s_nxt.cfg_locked = 1'b0;
			s_nxt.swen = 1'b0;
			s_nxt.to_flag = 1'b0;
			s_nxt.sleep_flag = 1'b0;
			s_nxt.idle_flag = 1'b0;
			s_nxt.mode = MODE_RUN;
			s_nxt.clear = 1'b1;
			s_nxt.ack = 1'b0;
			s_nxt.rdata = '0;
			s_nxt.rst_pulse = 1'b0;
			s_nxt.wake_pulse = 1'b0;
		end
	end

	always_ff @(posedge clock_in) begin
		s_r <= s_nxt;
	end

	assign wb_dat_out = s_r.rdata;
	assign wb_ack_out = s_r.ack;
	assign low_power_rc_osc_enable_out = s_r.cfg[CFG_HWEN_BIT] | s_r.swen;
	assign wdt_reset_out = s_r.rst_pulse;
	assign wake_out = s_r.wake_pulse;
	assign sleep_out = s_r.mode == MODE_SLEEP;
	assign idle_out = s_r.mode == MODE_IDLE;
endmodule : wwd_top

// ### tb/wwd_top_properties.sv
// Port checker of the watchdog top.
// Assumes it is bound into wwd_top.
`timescale 1ns/1ps
module wwd_top_properties
	import wwd_pkg::*;
(
	input wire logic clock_in,
	input wire logic srst_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [WB_ADR_W-1:0] wb_adr_in,
	input wire logic [WB_SEL_W-1:0] wb_sel_in,
	input wire logic [WB_DAT_W-1:0] wb_dat_in,
	input wire logic wb_ack_out,
	input wire logic low_power_rc_osc_enable_out,
	input wire logic wdt_reset_out,
	input wire logic wake_out,
	input wire logic sleep_out,
	input wire logic idle_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (srst_in);
	ack_after_req_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("no ack");
	ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack held");
	wdt_pulse_a: assert property (wdt_reset_out |=> !wdt_reset_out)
		else $error("reset held");
	wake_pulse_a: assert property (wake_out |=> !wake_out)
		else $error("wake held");
	reset_in_run_a: assert property (wdt_reset_out |-> !sleep_out && !idle_out)
		else $error("reset in sleep");
	mode_excl_a: assert property (!(sleep_out && idle_out))
		else $error("two modes");
	wake_exits_a: assert property (wake_out |-> ##[0:1] !sleep_out && !idle_out)
		else $error("no exit");
	sleep_entry_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out && wb_we_in
		&& wb_adr_in == OFS_CMD && wb_sel_in[0] && wb_dat_in[CMD_SLEEP_BIT] && !sleep_out
		&& !idle_out |-> ##[1:2] sleep_out) else $error("no sleep");
	low_power_rc_osc_reset_a: assert property ($fell(srst_in) |-> low_power_rc_osc_enable_out)
		else $error("rc off");
endmodule : wwd_top_properties

bind wwd_top wwd_top_properties i_props (.clock_in, .srst_in, .wb_cyc_in, .wb_stb_in,
	.wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_ack_out, .low_power_rc_osc_enable_out,
	.wdt_reset_out, .wake_out, .sleep_out, .idle_out);

// ### tb/wwd_top_tb.sv
// Self-checking bench of the watchdog top.
// Assumes a shortened RC divider of 4 clocks.
`timescale 1ns/1ps
module wwd_top_tb;
	import wwd_pkg::*;
	localparam int DIV = 4;
	logic clock_in = 0, srst_in = 1, wb_cyc_in = 0, wb_stb_in = 0, wb_we_in = 0;
	logic [WB_ADR_W-1:0] wb_adr_in = '0;
	logic [WB_SEL_W-1:0] wb_sel_in = 4'hF;
	logic [WB_DAT_W-1:0] wb_dat_in = '0, wb_dat_out, q;
	logic wb_ack_out, dev_reset_in = 0, clk_switch_done_in = 0, wake_event_in = 0;
	logic low_power_rc_osc_enable_out, wdt_reset_out, wake_out, sleep_out, idle_out;
	int fail_count = 0, checks = 0, cyc_n = 0, rst_n = 0, rst_at = 0, wake_n = 0;
	int m, n, p, pre, post;
	always #4 clock_in = ~clock_in;
	wwd_top #(.LOW_POWER_RC_OSC_DIV_P(DIV)) i_dut (.clock_in, .srst_in, .wb_cyc_in, .wb_stb_in,
		.wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
		.dev_reset_in, .clk_switch_done_in, .wake_event_in, .low_power_rc_osc_enable_out,
		.wdt_reset_out, .wake_out, .sleep_out, .idle_out);
	task automatic end_sim;
		if (fail_count == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %0t %s got %h exp %h", $time, s, got, exp);
		end
	endtask : chk
	function automatic int tmo(input int pr, input int po);
		return ((pr != 0) ? 128 : 32) * (1 << po) * DIV;
	endfunction : tmo
	always @(posedge clock_in) begin
		cyc_n++;
		if (wdt_reset_out === 1'b1) begin
			rst_n++;
			rst_at = cyc_n;
		end
		if (wake_out === 1'b1) wake_n++;
		if (cyc_n == 20000) begin
			fail_count++;
			end_sim();
		end
	end
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		k = 0;
		wb_cyc_in <= 1;
		wb_stb_in <= 1;
		wb_we_in <= w;
		wb_adr_in <= a;
		wb_dat_in <= d;
		do begin
			@(posedge clock_in);
			k++;
		end while (wb_ack_out !== 1'b1 && k < 20);
		q = wb_dat_out;
		chk(32'(k < 20), 1, "ack");
		wb_cyc_in <= 0;
		wb_stb_in <= 0;
		@(posedge clock_in);
	endtask : wb
	// One-cycle pulse on a side input: 0 device reset, 1 clock switch, 2 wake
	task automatic pulse(input int w);
		dev_reset_in <= (w == 0);
		clk_switch_done_in <= (w == 1);
		wake_event_in <= (w == 2);
		@(posedge clock_in);
		dev_reset_in <= 0;
		clk_switch_done_in <= 0;
		wake_event_in <= 0;
		repeat (2) @(posedge clock_in);
	endtask : pulse
	task automatic reset_dut;
		srst_in <= 1;
		repeat (5) @(posedge clock_in);
		srst_in <= 0;
		@(posedge clock_in);
	endtask : reset_dut
	task automatic wait_ev(input int lim, ref int cnt);
		int b;
		b = cnt;
		repeat (lim) if (cnt == b) @(posedge clock_in);
	endtask : wait_ev
	initial begin
		void'($urandom(32'h101BB039));
		for (pre = 0; pre < 2; pre++) begin
			post = $urandom % 3;
			reset_dut();
			wb(0, OFS_CONFIG, 0);
			chk(q, 32'hDF, "cfg rst");
			chk(low_power_rc_osc_enable_out, 1, "rc on");
			p = 32'h40 | (pre << 4) | post;
			wb(1, OFS_CONFIG, p);
			wb(1, OFS_CONFIG, 32'hDF);
			wb(0, OFS_CONFIG, 0);
			chk(q, p, "cfg");
			chk(low_power_rc_osc_enable_out, 0, "rc off");
			wb(0, OFS_STATUS, 0);
			chk(32'({q[STAT_LOCK_BIT], q[STAT_RUN_BIT]}), 32'h2, "lock");
			n = rst_n;
			wb(1, OFS_RESET_CONTROL_REG, 32'h20);
			m = cyc_n;
			wait_ev(tmo(pre, post) + 100, rst_n);
			chk(rst_n, n + 1, "tmo");
			chk(32'((rst_at - m - tmo(pre, post)) inside {[-8:8]}), 1, "period");
			wb(0, OFS_RESET_CONTROL_REG, 0);
			chk(q, 32'h10, "flag");
			wb(1, OFS_RESET_CONTROL_REG, 32'h30);
			pulse(0);
			wb(0, OFS_RESET_CONTROL_REG, 0);
			chk(q, 32'h10, "dev rst");
		end
		reset_dut();
		wb(1, OFS_CONFIG, 32'h80);
		repeat (40) @(posedge clock_in);
		pulse(1);
		wb(0, OFS_STATUS, 0);
		chk(32'(q[6:0] <= 1), 1, "switch");
		n = rst_n;
		wb(1, OFS_CMD, 1);
		chk(rst_n, n + 1, "early");
		repeat (40) begin
			wb(0, OFS_STATUS, 0);
			if (q[STAT_WIN_BIT]) break;
		end
		n = rst_n;
		wb(1, OFS_CMD, 1);
		chk(rst_n, n, "late");
		wb(0, OFS_STATUS, 0);
		chk(q[STAT_WIN_BIT], 0, "restart");
		wb(1, OFS_CMD, 2);
		chk(sleep_out, 1, "sleep");
		p = wake_n;
		wait_ev(300, wake_n);
		chk(wake_n, p + 1, "wake");
		chk(rst_n, n, "no rst");
		wb(0, OFS_RESET_CONTROL_REG, 0);
		chk(q[RESET_CONTROL_REG_SLEEP_BIT], 1, "sflag");
		wb(1, OFS_RESET_CONTROL_REG, 0);
		wb(0, OFS_RESET_CONTROL_REG, 0);
		chk(q, 0, "sclr");
		wb(1, OFS_CMD, 4);
		chk(idle_out, 1, "idle");
		pulse(2);
		chk(idle_out, 0, "exit");
		wb(0, OFS_RESET_CONTROL_REG, 0);
		chk(q[RESET_CONTROL_REG_IDLE_BIT], 1, "iflag");
		end_sim();
	end
endmodule : wwd_top_tb
